// ===== verilog/cbl_unit.sv
// condition bit logic unit: compare, leading zeros, cond bit logic
//
// How it works
// - unsigned compare of source with immediate zero-extended by 0x0000
// - compare result goes into the selected four-bit condition field
// - word-size flag set is invalid; unit flags it and skips update
// - logical-immediate compare recognised by base encoding x'2800 0000'
// - leading zero count from msb, 0 through 32, to destination register
// - record flag updates field zero with overflow copy, less-than cleared
// - leading zeros recognised by x'7C00 0034', low bit is record flag
// - x'4C00 0202' writes AND of two source bits
// - x'4C00 0102' writes first AND NOT second
// - x'4C00 0242' writes equivalence of the two source bits
// - x'4C00 01C2' writes NAND of the two source bits
// - x'4C00 0042' writes NOR of the two source bits
// - x'4C00 0382' writes OR of the two source bits
// - x'4C00 0342' writes first OR NOT second
// - x'4C00 0182' writes XOR of the two source bits
// - bit logic changes only the destination bit
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module cbl_unit (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] gpr_src_data,
    input wire logic summary_ovf,
    output logic gpr_wr_valid,
    output logic [4:0] gpr_wr_sel,
    output logic [31:0] gpr_wr_data,
    output logic [31:0] condition_bits,
    output logic bad_form_pulse,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata
);
    // msb-first bit number to vector index
    function automatic logic [4:0] bit_idx(input logic [4:0] n);
        return 5'd31 - n;
    endfunction

    function automatic logic [5:0] lead_zeros(input logic [31:0] v);
        logic [5:0] n;
        logic hit;
        n = 6'd0;
        hit = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                hit = 1'b1;
            end else if (!hit) begin
                n = n + 6'd1;
            end
        end
        return n;
    endfunction

    cbl_dec_if dec ();
    cbl_decode u_dec (
        .d(dec)
    );
    assign dec.instr = issue_instr;

    // bus slave state
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [3:0] wr_ofs_r;
    logic [3:0] wr_ofs_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic ctrl_en_r;
    logic ctrl_en_nxt;
    logic addr_phase;

    // execute state
    logic [31:0] cond_r;
    logic [31:0] cond_nxt;
    logic [31:0] cond_base;
    logic wb_valid_r;
    logic wb_valid_nxt;
    logic [4:0] wb_sel_r;
    logic [4:0] wb_sel_nxt;
    logic [31:0] wb_data_r;
    logic [31:0] wb_data_nxt;
    logic bad_r;
    logic bad_nxt;
    logic bad_pulse_r;
    logic bad_pulse_nxt;
    logic [5:0] last_cnt_r;
    logic [5:0] last_cnt_nxt;

    logic fire;
    logic bit_a;
    logic bit_b;
    logic [4:0] dst_i;
    logic [31:0] imm_ext;
    logic [5:0] clz_n;
    logic [2:0] cmp_c;
    logic [4:0] fld_top;
    logic bad_clr;

    assign addr_phase = hsel && htrans == cbl_pkg::HTRANS_NONSEQ && hready;
    assign hreadyout = 1'b1;
    assign hresp = cbl_pkg::HRESP_OKAY;
    assign hrdata = hrdata_r;

    // disabling stalls dispatch rather than dropping instructions
    assign issue_ready = ctrl_en_r;
    assign fire = issue_valid && issue_ready;

    // sources come from the registered copy, never from cond_nxt
    assign bit_a = cond_r[bit_idx(dec.first_src_cond_bit)];
    assign bit_b = cond_r[bit_idx(dec.second_src_cond_bit)];
    assign dst_i = bit_idx(dec.dest_cond_bit);
    assign imm_ext = {cbl_pkg::IMM_UPPER, dec.unsigned_imm16};
    assign clz_n = lead_zeros(gpr_src_data);
    assign fld_top = 5'd31 - {dec.target_cond_field, 2'b00};
    assign bad_clr = wr_pend_r && wr_ofs_r == cbl_pkg::STAT_OFS
        && hwdata[cbl_pkg::STAT_BAD_BIT];

    always_comb begin
        // unsigned compare of full word against extended immediate
        if (gpr_src_data < imm_ext) begin
            cmp_c = 3'b100;
        end else if (gpr_src_data > imm_ext) begin
            cmp_c = 3'b010;
        end else begin
            cmp_c = 3'b001;
        end
    end

    always_comb begin
        wr_pend_nxt = addr_phase && hwrite;
        wr_ofs_nxt = addr_phase ? haddr[3:0] : wr_ofs_r;
        ctrl_en_nxt = ctrl_en_r;
        hrdata_nxt = hrdata_r;
        if (wr_pend_r && wr_ofs_r == cbl_pkg::CTRL_OFS) begin
            ctrl_en_nxt = hwdata[cbl_pkg::CTRL_EN_BIT];
        end
        if (addr_phase && !hwrite) begin
            case (haddr[3:0])
                cbl_pkg::COND_OFS: hrdata_nxt = cond_r;
                cbl_pkg::CTRL_OFS: hrdata_nxt = {31'h0, ctrl_en_r};
                cbl_pkg::STAT_OFS: hrdata_nxt = {23'h0, bad_r, 2'h0,
                    last_cnt_r};
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 4'h0;
            hrdata_r <= 32'h0000_0000;
            ctrl_en_r <= cbl_pkg::CTRL_EN_RST;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_ofs_r <= wr_ofs_nxt;
            hrdata_r <= hrdata_nxt;
            ctrl_en_r <= ctrl_en_nxt;
        end
    end

    always_comb begin
        // a software write lands first; an instruction in the same
        // cycle then modifies the bits it owns on top of it
        cond_base = cond_r;
        if (wr_pend_r && wr_ofs_r == cbl_pkg::COND_OFS) begin
            cond_base = hwdata;
        end
        cond_nxt = cond_base;
        wb_valid_nxt = 1'b0;
        wb_sel_nxt = wb_sel_r;
        wb_data_nxt = wb_data_r;
        last_cnt_nxt = last_cnt_r;
        bad_pulse_nxt = 1'b0;
        if (fire) begin
            case (dec.op)
                cbl_pkg::OP_CMPLI: begin
                    if (dec.bad_form) begin
                        bad_pulse_nxt = 1'b1;
                    end else begin
                        cond_nxt[fld_top -: 4] = {cmp_c, summary_ovf};
                    end
                end
                cbl_pkg::OP_CLZ: begin
                    if (dec.bad_form) begin
                        bad_pulse_nxt = 1'b1;
                    end else begin
                        wb_valid_nxt = 1'b1;
                        wb_sel_nxt = dec.gpr_a_sel;
                        wb_data_nxt = {26'h0, clz_n};
                        last_cnt_nxt = clz_n;
                        if (dec.record_flag) begin
                            // count is never negative
                            cond_nxt[31:28] = {1'b0, clz_n != 6'd0,
                                clz_n == 6'd0, summary_ovf};
                        end
                    end
                end
                cbl_pkg::OP_AND: cond_nxt[dst_i] = bit_a & bit_b;
                cbl_pkg::OP_ANDC: cond_nxt[dst_i] = bit_a & ~bit_b;
                cbl_pkg::OP_EQV: cond_nxt[dst_i] = ~(bit_a ^ bit_b);
                cbl_pkg::OP_NAND: cond_nxt[dst_i] = ~(bit_a & bit_b);
                cbl_pkg::OP_NOR: cond_nxt[dst_i] = ~(bit_a | bit_b);
                cbl_pkg::OP_OR: cond_nxt[dst_i] = bit_a | bit_b;
                cbl_pkg::OP_ORC: cond_nxt[dst_i] = bit_a | ~bit_b;
                cbl_pkg::OP_XOR: cond_nxt[dst_i] = bit_a ^ bit_b;
                default: cond_nxt = cond_base;
            endcase
        end
        // sticky flag: a new bad form wins over a clear
        bad_nxt = (bad_r && !bad_clr) || bad_pulse_nxt;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_r <= cbl_pkg::COND_RST;
            wb_valid_r <= 1'b0;
            wb_sel_r <= 5'h00;
            wb_data_r <= 32'h0000_0000;
            bad_r <= 1'b0;
            bad_pulse_r <= 1'b0;
            last_cnt_r <= 6'h00;
        end else begin
            cond_r <= cond_nxt;
            wb_valid_r <= wb_valid_nxt;
            wb_sel_r <= wb_sel_nxt;
            wb_data_r <= wb_data_nxt;
            bad_r <= bad_nxt;
            bad_pulse_r <= bad_pulse_nxt;
            last_cnt_r <= last_cnt_nxt;
        end
    end

    assign gpr_wr_valid = wb_valid_r;
    assign gpr_wr_sel = wb_sel_r;
    assign gpr_wr_data = wb_data_r;
    assign condition_bits = cond_r;
    assign bad_form_pulse = bad_pulse_r;

    // checks; helper flags exclude cycles where software wrote cond
    logic sw_cond;
    logic is_cmp;
    logic is_lop;
    logic [31:0] keep_mask;
    assign sw_cond = wr_pend_r && wr_ofs_r == cbl_pkg::COND_OFS;
    assign is_cmp = fire && dec.op == cbl_pkg::OP_CMPLI && !dec.bad_form;
    assign is_lop = fire && dec.op inside {cbl_pkg::OP_AND,
        cbl_pkg::OP_ANDC, cbl_pkg::OP_EQV, cbl_pkg::OP_NAND,
        cbl_pkg::OP_NOR, cbl_pkg::OP_OR, cbl_pkg::OP_ORC, cbl_pkg::OP_XOR};
    assign keep_mask = ~(32'h0000_0001 << dst_i);

    sequence s_clz_issue;
        fire && dec.op == cbl_pkg::OP_CLZ && !dec.bad_form;
    endsequence

    sequence s_clz_wb;
        gpr_wr_valid && gpr_wr_data == {26'h0, $past(clz_n)};
    endsequence

    property p_cmp_value;
        @(posedge clk) disable iff (!arst_n)
        is_cmp |=> cond_r[$past(fld_top) -: 3] == $past(cmp_c);
    endproperty
    a_cmp_value: assert property (p_cmp_value)
        else $error("compare result wrong");

    property p_cmp_field;
        @(posedge clk) disable iff (!arst_n)
        is_cmp && !sw_cond |=> $onehot(cond_r[$past(fld_top) -: 3])
            && cond_r[$past(fld_top) - 5'd3] == $past(summary_ovf);
    endproperty
    a_cmp_field: assert property (p_cmp_field)
        else $error("compare field not one-hot with overflow copy");

    property p_cmp_other;
        @(posedge clk) disable iff (!arst_n)
        is_cmp && !sw_cond && dec.target_cond_field == 3'd0
            |=> cond_r[27:0] == $past(cond_r[27:0]);
    endproperty
    a_cmp_other: assert property (p_cmp_other)
        else $error("compare touched other fields");

    property p_bad_cmp;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_CMPLI && dec.bad_form && !sw_cond
            |=> cond_r == $past(cond_r) && bad_form_pulse ##1 bad_r;
    endproperty
    a_bad_cmp: assert property (p_bad_cmp)
        else $error("invalid compare form changed state");

    property p_decode_cmp;
        @(posedge clk) disable iff (!arst_n)
        issue_instr[31:26] == cbl_pkg::OPC_CMPLI |-> dec.op == cbl_pkg::OP_CMPLI;
    endproperty
    a_decode_cmp: assert property (p_decode_cmp)
        else $error("compare encoding not recognised");

    property p_clz;
        @(posedge clk) disable iff (!arst_n)
        s_clz_issue |=> s_clz_wb ##1 !gpr_wr_valid || $past(fire);
    endproperty
    a_clz: assert property (p_clz)
        else $error("leading zero count wrong");

    property p_clz_rec;
        @(posedge clk) disable iff (!arst_n)
        s_clz_issue and dec.record_flag |=> !cond_r[31]
            && cond_r[30] == ($past(clz_n) != 6'd0)
            && cond_r[29] == ($past(clz_n) == 6'd0)
            && cond_r[28] == $past(summary_ovf);
    endproperty
    a_clz_rec: assert property (p_clz_rec)
        else $error("record form field zero wrong");

    property p_clz_norec;
        @(posedge clk) disable iff (!arst_n)
        s_clz_issue and !dec.record_flag and !sw_cond
            |=> cond_r == $past(cond_r);
    endproperty
    a_clz_norec: assert property (p_clz_norec)
        else $error("non-record form changed condition bits");

    property p_and;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_AND
            |=> cond_r[$past(dst_i)] == ($past(bit_a) & $past(bit_b));
    endproperty
    a_and: assert property (p_and)
        else $error("and result wrong");

    property p_andc;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_ANDC
            |=> cond_r[$past(dst_i)] == ($past(bit_a) & !$past(bit_b));
    endproperty
    a_andc: assert property (p_andc)
        else $error("and-complement result wrong");

    property p_eqv;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_EQV
            |=> cond_r[$past(dst_i)] == ($past(bit_a) == $past(bit_b));
    endproperty
    a_eqv: assert property (p_eqv)
        else $error("equivalence result wrong");

    property p_nand;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_NAND
            |=> cond_r[$past(dst_i)] == !($past(bit_a) && $past(bit_b));
    endproperty
    a_nand: assert property (p_nand)
        else $error("nand result wrong");

    property p_nor;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_NOR
            |=> cond_r[$past(dst_i)] == !($past(bit_a) || $past(bit_b));
    endproperty
    a_nor: assert property (p_nor)
        else $error("nor result wrong");

    property p_or;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_OR
            |=> cond_r[$past(dst_i)] == ($past(bit_a) | $past(bit_b));
    endproperty
    a_or: assert property (p_or)
        else $error("or result wrong");

    property p_orc;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_ORC
            |=> cond_r[$past(dst_i)] == ($past(bit_a) | !$past(bit_b));
    endproperty
    a_orc: assert property (p_orc)
        else $error("or-complement result wrong");

    property p_xor;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_XOR
            |=> cond_r[$past(dst_i)] == ($past(bit_a) ^ $past(bit_b));
    endproperty
    a_xor: assert property (p_xor)
        else $error("xor result wrong");

    property p_lop_keep;
        @(posedge clk) disable iff (!arst_n)
        is_lop && !sw_cond |=> (cond_r & $past(keep_mask))
            == ($past(cond_r) & $past(keep_mask));
    endproperty
    a_lop_keep: assert property (p_lop_keep)
        else $error("bit logic changed another bit");

    property p_lop_self;
        @(posedge clk) disable iff (!arst_n)
        fire && dec.op == cbl_pkg::OP_XOR
            && dec.dest_cond_bit == dec.first_src_cond_bit
            && dec.dest_cond_bit == dec.second_src_cond_bit
            |=> !cond_r[$past(dst_i)];
    endproperty
    a_lop_self: assert property (p_lop_self)
        else $error("self xor did not clear bit");
endmodule

// ===== include/cbl_pkg.sv
// shared constants and types for the condition bit logic unit
package cbl_pkg;
    // primary and extended opcodes
    localparam logic [5:0] OPC_CMPLI = 6'h0a;
    localparam logic [5:0] OPC_X31 = 6'h1f;
    localparam logic [5:0] OPC_X19 = 6'h13;
    localparam logic [9:0] XO_CLZ = 10'h01a;
    localparam logic [9:0] XO_AND = 10'h101;
    localparam logic [9:0] XO_ANDC = 10'h081;
    localparam logic [9:0] XO_EQV = 10'h121;
    localparam logic [9:0] XO_NAND = 10'h0e1;
    localparam logic [9:0] XO_NOR = 10'h021;
    localparam logic [9:0] XO_OR = 10'h1c1;
    localparam logic [9:0] XO_ORC = 10'h1a1;
    localparam logic [9:0] XO_XOR = 10'h0c1;
    // upper half that zero-extends the immediate
    localparam logic [15:0] IMM_UPPER = 16'h0000;
    // register offsets
    localparam logic [3:0] COND_OFS = 4'h0;
    localparam logic [3:0] CTRL_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_BAD_BIT = 8;
    localparam int STAT_CNT_W = 6;
    // reset values and bus encodings
    localparam logic [31:0] COND_RST = 32'h0000_0000;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [3:0] {
        OP_NONE, OP_CMPLI, OP_CLZ, OP_AND, OP_ANDC, OP_EQV,
        OP_NAND, OP_NOR, OP_OR, OP_ORC, OP_XOR
    } cbl_op_type;
endpackage

// ===== include/cbl_dec_if.sv
// decoded instruction fields passed from decoder to execute logic
`timescale 1ns/100ps
interface cbl_dec_if;
    logic [31:0] instr;
    cbl_pkg::cbl_op_type op;
    logic [2:0] target_cond_field;
    logic [4:0] gpr_a_sel;
    logic [4:0] gpr_s_sel;
    logic [4:0] dest_cond_bit;
    logic [4:0] first_src_cond_bit;
    logic [4:0] second_src_cond_bit;
    logic [15:0] unsigned_imm16;
    logic record_flag;
    logic bad_form;
    modport dec (input instr, output op, target_cond_field, gpr_a_sel,
        gpr_s_sel, dest_cond_bit, first_src_cond_bit,
        second_src_cond_bit, unsigned_imm16, record_flag, bad_form);
    modport exe (output instr, input op, target_cond_field, gpr_a_sel,
        gpr_s_sel, dest_cond_bit, first_src_cond_bit,
        second_src_cond_bit, unsigned_imm16, record_flag, bad_form);
endinterface

// ===== verilog/cbl_decode.sv
// instruction decoder for the condition bit logic unit
`timescale 1ns/100ps
module cbl_decode (
    cbl_dec_if.dec d
);
    logic [5:0] opc;
    logic [9:0] xo;

    assign opc = d.instr[31:26];
    assign xo = d.instr[10:1];
    // fields are numbered from the msb, so bit 0 is instr[31]
    assign d.target_cond_field = d.instr[25:23];
    assign d.gpr_s_sel = d.instr[25:21];
    assign d.dest_cond_bit = d.instr[25:21];
    assign d.gpr_a_sel = d.instr[20:16];
    assign d.first_src_cond_bit = d.instr[20:16];
    assign d.second_src_cond_bit = d.instr[15:11];
    assign d.unsigned_imm16 = d.instr[15:0];
    assign d.record_flag = d.instr[0];

    always_comb begin
        d.op = cbl_pkg::OP_NONE;
        d.bad_form = 1'b0;
        if (opc == cbl_pkg::OPC_CMPLI) begin
            d.op = cbl_pkg::OP_CMPLI;
            d.bad_form = d.instr[21];
        end else if (opc == cbl_pkg::OPC_X31 && xo == cbl_pkg::XO_CLZ) begin
            d.op = cbl_pkg::OP_CLZ;
            d.bad_form = |d.instr[15:11];
        end else if (opc == cbl_pkg::OPC_X19 && !d.instr[0]) begin
            case (xo)
                cbl_pkg::XO_AND: d.op = cbl_pkg::OP_AND;
                cbl_pkg::XO_ANDC: d.op = cbl_pkg::OP_ANDC;
                cbl_pkg::XO_EQV: d.op = cbl_pkg::OP_EQV;
                cbl_pkg::XO_NAND: d.op = cbl_pkg::OP_NAND;
                cbl_pkg::XO_NOR: d.op = cbl_pkg::OP_NOR;
                cbl_pkg::XO_OR: d.op = cbl_pkg::OP_OR;
                cbl_pkg::XO_ORC: d.op = cbl_pkg::OP_ORC;
                cbl_pkg::XO_XOR: d.op = cbl_pkg::OP_XOR;
                default: d.op = cbl_pkg::OP_NONE;
            endcase
        end
    end
endmodule

// ===== verif/cbl_dispatch_model.sv
// dispatch-side model offering instructions to the unit
`timescale 1ns/100ps
module cbl_dispatch_model (
    input wire logic clk,
    input wire logic issue_ready,
    output logic issue_valid,
    output logic [31:0] issue_instr,
    output logic [31:0] gpr_src_data,
    output logic summary_ovf
);
    initial begin
        issue_valid = 1'b0;
        issue_instr = 32'h0000_0000;
        gpr_src_data = 32'h0000_0000;
        summary_ovf = 1'b0;
    end

    // holds the offer until taken or 20 cycles pass; invalid forms only when asked
    task automatic send(input logic [31:0] ins, input logic [31:0] dat,
        input logic so, output logic ok);
        int n;
        @(posedge clk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        gpr_src_data <= dat;
        summary_ovf <= so;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = (issue_ready === 1'b1);
        end
        issue_valid <= 1'b0;
        // released lines flip so stale values never look valid
        issue_instr <= ~ins;
        gpr_src_data <= ~dat;
    endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the condition bit logic unit
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [31:0] base;
        logic [3:0] tt;
        logic [4:0] d, a, b;
    } cbl_lg_type;
    typedef struct packed {
        logic [31:0] g;
        logic [15:0] imm;
        logic [2:0] f;
        logic so;
        logic [2:0] res;
    } cbl_cm_type;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic issue_valid, issue_ready, summary_ovf, ok;
    logic gpr_wr_valid, bad_form_pulse, hreadyout;
    logic [4:0] gpr_wr_sel;
    logic [31:0] issue_instr, gpr_src_data, gpr_wr_data;
    logic [31:0] condition_bits, hrdata, rd, c;
    logic [1:0] hresp;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    int fails = 0;
    int checks = 0;
    int i, j;
    // truth table indexed by {first, second} source bit
    cbl_lg_type lg [8] = '{
        '{32'h4c00_0202, 4'h8, 5'd3, 5'd3, 5'd9},
        '{32'h4c00_0102, 4'h4, 5'd0, 5'd1, 5'd2},
        '{32'h4c00_0242, 4'h9, 5'd31, 5'd30, 5'd31},
        '{32'h4c00_01c2, 4'h7, 5'd17, 5'd4, 5'd28},
        '{32'h4c00_0042, 4'h1, 5'd8, 5'd16, 5'd24},
        '{32'h4c00_0382, 4'he, 5'd12, 5'd12, 5'd5},
        '{32'h4c00_0342, 4'hd, 5'd21, 5'd22, 5'd20},
        '{32'h4c00_0182, 4'h6, 5'd7, 5'd11, 5'd7}
    };
    // immediates with top bit set catch a sign extension
    cbl_cm_type cm [4] = '{
        '{32'h0001_0000, 16'hffff, 3'd7, 1'b1, 3'b010},
        '{32'h0000_ffff, 16'hffff, 3'd0, 1'b0, 3'b001},
        '{32'h0000_0005, 16'h8000, 3'd3, 1'b1, 3'b100},
        '{32'h8000_0000, 16'h0001, 3'd5, 1'b0, 3'b010}
    };
    logic [37:0] lz [4] = '{{32'h0, 6'd32}, {32'h8000_0000, 6'd0},
        {32'h0001_0000, 6'd15}, {32'h0000_0001, 6'd31}};

    always #12.5 clk = ~clk;

    cbl_dispatch_model disp (
        .clk(clk),
        .issue_ready(issue_ready),
        .issue_valid(issue_valid),
        .issue_instr(issue_instr),
        .gpr_src_data(gpr_src_data),
        .summary_ovf(summary_ovf)
    );

    cbl_unit dut (
        .clk(clk),
        .arst_n(arst_n),
        .issue_valid(issue_valid),
        .issue_ready(issue_ready),
        .issue_instr(issue_instr),
        .gpr_src_data(gpr_src_data),
        .summary_ovf(summary_ovf),
        .gpr_wr_valid(gpr_wr_valid),
        .gpr_wr_sel(gpr_wr_sel),
        .gpr_wr_data(gpr_wr_data),
        .condition_bits(condition_bits),
        .bad_form_pulse(bad_form_pulse),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata)
    );

    task automatic report_and_stop;
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask

    task automatic wait_rdy;
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            report_and_stop;
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= cbl_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
        check({30'h0, hresp}, 32'h0, "hresp");
    endtask

    // results register at the taking edge; pulses last one cycle only
    task automatic issue(input logic [31:0] ins, dat, input logic so);
        disp.send(ins, dat, so, ok);
        #1;
        check({31'h0, ok}, 32'h1, "issue taken");
        if (ok !== 1'b1) report_and_stop;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check(condition_bits, cbl_pkg::COND_RST, "reset cond");
        ahb(1'b0, 32'h4, 32'h0);
        check(rd, {31'h0, cbl_pkg::CTRL_EN_RST}, "ctrl reset");
        ahb(1'b0, 32'hc, 32'h0);
        check(rd, 32'h0, "unmapped read");
        for (i = 0; i < 8; i++) begin
            for (j = 0; j < 4; j++) begin
                c = 32'h9c3a_65e1;
                c[31 - lg[i].a] = j[1];
                c[31 - lg[i].b] = j[0];
                ahb(1'b1, 32'h0, c);
                issue(lg[i].base | {6'h0, lg[i].d, lg[i].a, lg[i].b,
                    11'h0}, 32'h0, 1'b0);
                c[31 - lg[i].d] = lg[i].tt[j];
                check(condition_bits, c, "bit logic");
            end
        end
        c = 32'h0f0f_f0f0;
        ahb(1'b1, 32'h0, c);
        for (i = 0; i < 4; i++) begin
            issue(32'h2800_0000 | {6'h0, cm[i].f, 7'h04, cm[i].imm},
                cm[i].g, cm[i].so);
            c[31 - 4 * cm[i].f -: 4] = {cm[i].res, cm[i].so};
            check(condition_bits, c, "compare");
        end
        issue(32'h2920_0000, 32'h0, 1'b1);
        check(condition_bits, c, "bad form kept");
        check({31'h0, bad_form_pulse}, 32'h1, "bad form flag");
        for (i = 0; i < 4; i++) begin
            issue(32'h7c00_0034 | {6'h0, 5'd6, 5'(i + 1), 15'h0, i[0]},
                lz[i][37:6], i[1]);
            check(gpr_wr_data, {26'h0, lz[i][5:0]}, "count");
            check({27'h0, gpr_wr_sel}, 32'(i + 1), "dest");
            check({31'h0, gpr_wr_valid}, 32'h1, "wr valid");
            if (i[0])
                c[31 -: 4] = {1'b0, lz[i][5:0] != 0, lz[i][5:0] == 0, i[1]};
            check(condition_bits, c, "record");
        end
        // disabled unit must refuse, so the state stays put
        ahb(1'b1, 32'h4, 32'h0);
        #1;
        check({31'h0, issue_ready}, 32'h0, "ready off");
        disp.send(32'h4c00_0242, 32'h0, 1'b0, ok);
        check({31'h0, ok}, 32'h0, "refused");
        check(condition_bits, c, "no change");
        ahb(1'b1, 32'h4, 32'h1);
        // stray reserved bit in a leading zero count must be dropped
        issue(32'h7c00_0835, 32'h0, 1'b0);
        check({31'h0, gpr_wr_valid}, 32'h0, "clz bad write");
        check({31'h0, bad_form_pulse}, 32'h1, "clz bad flag");
        check(condition_bits, c, "clz bad kept");
        ahb(1'b0, 32'h8, 32'h0);
        check(rd, 32'h0000_011f, "stat sticky");
        ahb(1'b1, 32'h8, 32'h0000_0100);
        ahb(1'b0, 32'h8, 32'h0);
        check(rd, 32'h0000_001f, "stat cleared");
        // reset in mid run must bring cond bits, ready and read data back to reset values
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check(condition_bits, cbl_pkg::COND_RST, "mid reset cond");
        check({31'h0, issue_ready}, 32'h1, "mid reset ready");
        check(hrdata, 32'h0, "mid reset rdata");
        report_and_stop;
    end
endmodule
